// *** logic/led_pump_pkg.sv ***
/*
 * constants, register map, states and carrier types for the led charge-pump mode control.
 * assumes a 10 MHz oscillator clock and a single AHB-Lite master on the register port.
 */
package led_pump_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int PUMP_FREQ_HZ = 850_000;
	localparam int PUMP_PERIOD_CYC = CLK_HZ / PUMP_FREQ_HZ;
	localparam int PUMP_HALF_CYC = PUMP_PERIOD_CYC / 2;
	localparam int HOLDOFF_MS = 1;
	localparam int HOLDOFF_CYC = (HOLDOFF_MS * CLK_HZ + 999) / 1000;
	localparam int DROPOUT_DELAY_US = 2500;
	localparam int DROPOUT_CYC = DROPOUT_DELAY_US * (CLK_HZ / 1_000_000);
	localparam int SOFTSTART_US = 125;
	localparam int SOFTSTART_CYC = SOFTSTART_US * (CLK_HZ / 1_000_000);
	localparam int PWM_MIN_ON_US = 50;
	localparam int PWM_MIN_ON_CYC = PWM_MIN_ON_US * (CLK_HZ / 1_000_000);
	localparam int PWM_QUAL_EDGES = 2;
	localparam int CNT_W = 16;
	localparam int RAMP_W = 11;
	localparam int PH_W = 4;
	localparam logic [31:0] REG_CONFIG = 32'h0000_0000;
	localparam logic [31:0] REG_STATUS = 32'h0000_0004;
	localparam int CFG_AUTO_STEP_BIT = 0;
	localparam logic [31:0] CFG_RESET = 32'h0000_0001;
	localparam int ST_MODE_LSB = 0;
	localparam int ST_POWER_LSB = 3;
	localparam int ST_PWM_BIT = 6;
	localparam int ST_MAIN_OK_BIT = 7;
	localparam int ST_DROPOUT_BIT = 8;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'h0;

	typedef enum logic [2:0] {
		PM_1X = 3'b001,
		PM_1P5X = 3'b010,
		PM_2X = 3'b100
	} pump_mode_type;

	typedef enum logic [2:0] {
		PS_SHUT = 3'b001,
		PS_ON = 3'b010,
		PS_OCP = 3'b100
	} power_state_type;

	typedef struct packed {
		logic phase_one;
		logic phase_two;
		logic series_charge;
		logic parallel_stack;
		logic cap_one_charge;
		logic cap_two_charge;
		logic main_bypass;
		logic weak_bypass;
	} pump_switch_type;

	typedef struct packed {
		logic cpo_at_or_below_supply;
		logic dropout;
		logic short_b;
		logic short_a;
		logic high_level_select;
		logic low_level_select;
	} sense_type;
endpackage : led_pump_pkg

// *** logic/led_charge_pump_mode_control.sv ***
/*
 * mode control for a multi-led charge pump: enable decode, shutdown hold-off, dropout
 * stepping 1x/1.5x/2x, non-overlapping pump clock, soft-start ramp, overcurrent shutdown,
 * and an AHB-Lite register slave. assumes every sense input is asynchronous and that
 * the oscillator clock runs whenever supply is present.
 */
// Operation
// - decode enables: none shutdown, first low, second high, both low plus high
// - pump output is on in any current setting and off in shutdown
// - first enable low: shut down only after second enable low for 1 ms
// - first enable high: no limit on second enable low time
// - leaving shutdown the pump starts in 1x, supply tied to output
// - stay in 1x until dropout, then step to 1.5x
// - further dropout in 1.5x steps to 2x
// - shutdown returns the mode to 1x
// - two-phase non-overlapping pump clock at nominal 850 kHz (code: 11-cycle period, about 909 kHz)
// - in 2x each flying capacitor charges from supply on alternate phases
// - in 1.5x caps charge in series, then stack in parallel on supply
// - on each step-up pump strength ramps linearly over about 125 us
// - in shutdown only a weak switch ties supply to the output
// - a shorted programming resistor forces overcurrent shutdown
// - wait about 2.5 ms of dropout before stepping mode
// - under pwm, dropout qualifies over one to two enable pulses
// - after return to 1x main switch waits for output at or below supply
`timescale 1ns/1ps
`default_nettype none
module led_charge_pump_mode_control
	import led_pump_pkg::*;
#(
	parameter int HOLDOFF_CYCLES = HOLDOFF_CYC,
	parameter int DROPOUT_CYCLES = DROPOUT_CYC
) (
	input wire logic CLK,
	input wire logic RSTN,
	input wire sense_type SENSE,
	output var logic PUMP_ENABLE,
	output var logic LOW_CURRENT_EN,
	output var logic HIGH_CURRENT_EN,
	output var logic OVERCURRENT,
	output var pump_mode_type PUMP_MODE,
	output var logic [RAMP_W-1:0] PUMP_STRENGTH,
	output var pump_switch_type PUMP_SWITCHES,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output var logic HREADYOUT,
	output var logic [31:0] HRDATA,
	output var logic HRESP
);
	localparam int NSENSE = $bits(sense_type);

	// two-stage synchronisers, one per sense input
	wire [NSENSE-1:0] sync_w;
	sense_type s;
	genvar gi;
	generate
		for (gi = 0; gi < NSENSE; gi++) begin : g_sync
			logic meta_r;
			logic stable_r;
			always_ff @(posedge CLK or negedge RSTN) begin
				if (!RSTN) begin
					meta_r <= 1'b0;
					stable_r <= 1'b0;
				end else begin
					meta_r <= SENSE[gi];
					stable_r <= meta_r;
				end
			end
			assign sync_w[gi] = stable_r;
		end
	endgenerate
	assign s = sense_type'(sync_w);

	function automatic logic any_enable(input sense_type v);
		return v.low_level_select | v.high_level_select;
	endfunction

	// control state
	power_state_type ps_r, ps_nxt;
	pump_mode_type mode_r, mode_nxt;
	logic [CNT_W-1:0] hold_r, hold_nxt;
	logic [CNT_W-1:0] drop_r, drop_nxt;
	logic [1:0] edges_r, edges_nxt;
	logic hls_d_r, hls_d_nxt;
	logic pwm_r, pwm_nxt;
	logic main_ok_r, main_ok_nxt;
	logic [RAMP_W-1:0] ramp_r, ramp_nxt;
	logic [PH_W-1:0] ph_r, ph_nxt;
	logic auto_step_r;
	logic step;
	logic qualified;

	always_comb begin
		ps_nxt = ps_r;
		mode_nxt = mode_r;
		hold_nxt = hold_r;
		drop_nxt = drop_r;
		edges_nxt = edges_r;
		hls_d_nxt = s.high_level_select;
		pwm_nxt = pwm_r;
		main_ok_nxt = main_ok_r;
		ramp_nxt = ramp_r;
		step = 1'b0;
		qualified = 1'b0;
		ph_nxt = (ph_r == PH_W'(PUMP_PERIOD_CYC - 1)) ? '0 : ph_r + 1'b1;
		case (ps_r)
			PS_SHUT: begin
				mode_nxt = PM_1X;
				hold_nxt = '0;
				drop_nxt = '0;
				edges_nxt = '0;
				pwm_nxt = 1'b0;
				main_ok_nxt = 1'b0;
				ramp_nxt = '0;
				if (any_enable(s)) begin
					ps_nxt = PS_ON;
				end
			end
			PS_ON: begin
				if (any_enable(s)) begin
					hold_nxt = '0;
				end else if (hold_r >= CNT_W'(HOLDOFF_CYCLES - 1)) begin
					ps_nxt = PS_SHUT;
				end else begin
					hold_nxt = hold_r + 1'b1;
				end
				if (hls_d_r && !s.high_level_select) begin
					pwm_nxt = 1'b1;
				end
				if (s.cpo_at_or_below_supply) begin
					main_ok_nxt = 1'b1;
				end
				if (mode_r != PM_1X && ramp_r < RAMP_W'(SOFTSTART_CYC)) begin
					ramp_nxt = ramp_r + 1'b1;
				end
				if (!s.dropout || !auto_step_r || mode_r == PM_2X) begin
					drop_nxt = '0;
					edges_nxt = '0;
				end else begin
					drop_nxt = (drop_r == '1) ? drop_r : drop_r + 1'b1;
					if (!hls_d_r && s.high_level_select && edges_r != 2'h3) begin
						edges_nxt = edges_r + 1'b1;
					end
					qualified = pwm_r ? (edges_r >= 2'(PWM_QUAL_EDGES))
						: (drop_r >= CNT_W'(DROPOUT_CYCLES - 1));
				end
				if (qualified) begin
					step = 1'b1;
					drop_nxt = '0;
					edges_nxt = '0;
					ramp_nxt = '0;
					mode_nxt = (mode_r == PM_1X) ? PM_1P5X : PM_2X;
				end
				if (s.short_a || s.short_b) begin
					ps_nxt = PS_OCP;
				end
			end
			PS_OCP: begin
				mode_nxt = PM_1X;
				ramp_nxt = '0;
				main_ok_nxt = 1'b0;
				if (!any_enable(s) && !s.short_a && !s.short_b) begin
					ps_nxt = PS_SHUT;
				end
			end
			default: begin
				ps_nxt = PS_SHUT;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ps_r <= PS_SHUT;
			mode_r <= PM_1X;
			hold_r <= '0;
			drop_r <= '0;
			edges_r <= '0;
			hls_d_r <= 1'b0;
			pwm_r <= 1'b0;
			main_ok_r <= 1'b0;
			ramp_r <= '0;
			ph_r <= '0;
		end else begin
			ps_r <= ps_nxt;
			mode_r <= mode_nxt;
			hold_r <= hold_nxt;
			drop_r <= drop_nxt;
			edges_r <= edges_nxt;
			hls_d_r <= hls_d_nxt;
			pwm_r <= pwm_nxt;
			main_ok_r <= main_ok_nxt;
			ramp_r <= ramp_nxt;
			ph_r <= ph_nxt;
		end
	end

	// output stage, all registered
	pump_switch_type sw_nxt;
	logic on_nxt;
	logic p1;
	logic p2;
	always_comb begin
		on_nxt = (ps_nxt == PS_ON);
		// one dead cycle at each half keeps the phases apart
		p1 = on_nxt && ph_r >= PH_W'(1) && ph_r < PH_W'(PUMP_HALF_CYC);
		p2 = on_nxt && ph_r > PH_W'(PUMP_HALF_CYC);
		sw_nxt = '0;
		sw_nxt.weak_bypass = (ps_nxt != PS_ON);
		sw_nxt.main_bypass = on_nxt && mode_nxt == PM_1X && main_ok_nxt;
		if (mode_nxt != PM_1X) begin
			sw_nxt.phase_one = p1;
			sw_nxt.phase_two = p2;
		end
		if (mode_nxt == PM_1P5X) begin
			sw_nxt.series_charge = p1;
			sw_nxt.parallel_stack = p2;
		end
		if (mode_nxt == PM_2X) begin
			sw_nxt.cap_one_charge = p1;
			sw_nxt.cap_two_charge = p2;
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			PUMP_ENABLE <= 1'b0;
			LOW_CURRENT_EN <= 1'b0;
			HIGH_CURRENT_EN <= 1'b0;
			OVERCURRENT <= 1'b0;
			PUMP_MODE <= PM_1X;
			PUMP_STRENGTH <= '0;
			PUMP_SWITCHES <= 8'h01;
		end else begin
			PUMP_ENABLE <= on_nxt;
			LOW_CURRENT_EN <= on_nxt && s.low_level_select;
			HIGH_CURRENT_EN <= on_nxt && s.high_level_select;
			OVERCURRENT <= (ps_nxt == PS_OCP);
			PUMP_MODE <= mode_nxt;
			PUMP_STRENGTH <= ramp_nxt;
			PUMP_SWITCHES <= sw_nxt;
		end
	end

	// AHB-Lite slave, zero wait states, always OKAY
	logic wr_pend_r, wr_pend_nxt;
	logic [31:0] wr_addr_r, wr_addr_nxt;
	logic [31:0] cfg_r, cfg_nxt;
	logic [31:0] rdata_nxt;
	logic addr_ok;
	logic [31:0] status;
	always_comb begin
		addr_ok = HSEL && HREADY && HTRANS == HTRANS_NONSEQ;
		status = '0;
		status[ST_MODE_LSB +: 3] = mode_r;
		status[ST_POWER_LSB +: 3] = ps_r;
		status[ST_PWM_BIT] = pwm_r;
		status[ST_MAIN_OK_BIT] = main_ok_r;
		status[ST_DROPOUT_BIT] = s.dropout;
		wr_pend_nxt = addr_ok && HWRITE;
		wr_addr_nxt = addr_ok ? HADDR : wr_addr_r;
		cfg_nxt = cfg_r;
		if (wr_pend_r && wr_addr_r == REG_CONFIG) begin
			cfg_nxt = {31'h0000_0000, HWDATA[CFG_AUTO_STEP_BIT]};
		end
		rdata_nxt = '0;
		if (addr_ok && !HWRITE) begin
			case (HADDR)
				REG_CONFIG: rdata_nxt = cfg_r;
				REG_STATUS: rdata_nxt = status;
				default: rdata_nxt = '0;
			endcase
		end
	end
	assign auto_step_r = cfg_r[CFG_AUTO_STEP_BIT];

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= '0;
			cfg_r <= CFG_RESET;
			HRDATA <= '0;
			HREADYOUT <= 1'b1;
			HRESP <= HRESP_OKAY;
		end else begin
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			cfg_r <= cfg_nxt;
			HRDATA <= rdata_nxt;
			HREADYOUT <= 1'b1;
			HRESP <= HRESP_OKAY;
		end
	end

	// checks
	sequence s_step_up;
		$changed(PUMP_MODE) && PUMP_MODE != PM_1X;
	endsequence
	sequence s_ramp_from_zero;
		PUMP_STRENGTH == '0 ##1 PUMP_STRENGTH == RAMP_W'(1);
	endsequence

	a_decode_levels: assert property (@(posedge CLK) disable iff (!RSTN)
		ps_r == PS_ON ##0 ps_nxt == PS_ON |=> LOW_CURRENT_EN == $past(s.low_level_select)
		&& HIGH_CURRENT_EN == $past(s.high_level_select)) else $error("enable decode wrong");
	a_pump_shutdown: assert property (@(posedge CLK) disable iff (!RSTN)
		ps_r == PS_SHUT |-> !PUMP_ENABLE || $past(ps_r) == PS_ON) else $error("pump on in shutdown");
	a_holdoff_clear: assert property (@(posedge CLK) disable iff (!RSTN)
		ps_r == PS_ON && any_enable(s) |=> hold_r == '0) else $error("hold-off not cleared");
	a_no_early_shut: assert property (@(posedge CLK) disable iff (!RSTN)
		ps_r == PS_ON ##1 ps_r == PS_SHUT |-> $past(hold_r) == CNT_W'(HOLDOFF_CYCLES - 1))
		else $error("shutdown before hold-off");
	a_first_keeps_on: assert property (@(posedge CLK) disable iff (!RSTN)
		ps_r == PS_ON && s.low_level_select && !s.short_a && !s.short_b |=> ps_r == PS_ON)
		else $error("shutdown with first enable high");
	a_step_single: assert property (@(posedge CLK) disable iff (!RSTN)
		$past(mode_r) == PM_1X |-> mode_r != PM_2X) else $error("skipped 1.5x");
	a_shut_mode: assert property (@(posedge CLK) disable iff (!RSTN)
		ps_r == PS_SHUT |=> mode_r == PM_1X) else $error("mode not reset");
	a_mode_saturate: assert property (@(posedge CLK) disable iff (!RSTN)
		mode_r == PM_2X && ps_r == PS_ON ##1 ps_r == PS_ON |-> mode_r == PM_2X) else $error("left 2x");
	a_no_overlap: assert property (@(posedge CLK) disable iff (!RSTN)
		!(PUMP_SWITCHES.phase_one && PUMP_SWITCHES.phase_two)) else $error("phases overlap");
	a_ramp_restart: assert property (@(posedge CLK) disable iff (!RSTN)
		s_step_up ##0 ps_r == PS_ON |-> s_ramp_from_zero) else $error("no soft-start");
	a_drop_delay: assert property (@(posedge CLK) disable iff (!RSTN)
		step && !pwm_r |-> drop_r == CNT_W'(DROPOUT_CYCLES - 1)) else $error("step before dropout delay");
	a_pwm_qualify: assert property (@(posedge CLK) disable iff (!RSTN)
		step && pwm_r |-> edges_r == 2'(PWM_QUAL_EDGES)) else $error("pwm step without two pulses");
	a_main_waits: assert property (@(posedge CLK) disable iff (!RSTN)
		PUMP_SWITCHES.main_bypass |-> main_ok_r) else $error("main switch early");
	a_ocp_entry: assert property (@(posedge CLK) disable iff (!RSTN)
		ps_r == PS_ON && s.short_a |=> OVERCURRENT && !PUMP_ENABLE) else $error("no overcurrent stop");
	a_weak_only: assert property (@(posedge CLK) disable iff (!RSTN)
		ps_r == PS_SHUT ##1 ps_r == PS_SHUT |-> PUMP_SWITCHES.weak_bypass && !PUMP_SWITCHES.main_bypass)
		else $error("weak switch missing");
endmodule : led_charge_pump_mode_control
`default_nettype wire

// *** tb/enable_host.sv ***
/*
 * host model that drives the two enable pins, as levels or with pwm on the second one.
 * assumes the bench asks for levels on the same clock that the device runs on.
 */
`timescale 1ns/1ps
`default_nettype none
module enable_host
	import led_pump_pkg::*;
#(
	parameter int OFF_CYC = 300
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic low_req,
	input wire logic high_req,
	input wire logic pwm_req,
	output var logic low_sel,
	output var logic high_sel
);
	int cnt;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			low_sel <= 1'b0;
			high_sel <= 1'b0;
			cnt <= 0;
		end else begin
			low_sel <= low_req;
			cnt <= cnt + 1;
			if (!pwm_req) begin
				high_sel <= high_req;
				cnt <= 0;
			end else if (high_sel && cnt >= PWM_MIN_ON_CYC - 1) begin
				high_sel <= 1'b0;
				cnt <= 0;
			end else if (!high_sel && cnt >= OFF_CYC - 1) begin
				high_sel <= 1'b1;
				cnt <= 0;
			end
		end
	end
endmodule : enable_host
`default_nettype wire

// *** tb/led_charge_pump_mode_control_tb_top.sv ***
/*
 * self-checking bench: enable decode, hold-off, dropout stepping, pump clock, ocp, registers.
 * assumes zero-wait AHB-Lite slave and shortened hold-off and dropout counts.
 */
`timescale 1ns/1ps
`default_nettype none
module led_charge_pump_mode_control_tb_top
	import led_pump_pkg::*;
;
	localparam int HOLD = 40;
	localparam int DROP = 60;
	logic CLK = 0, RSTN = 0, lo_req = 0, hi_req = 0, pwm_req = 0;
	logic pump_output = 0, drop = 0, sa = 0, sb = 0, hsel = 0, hwrite = 0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
	logic lo, hi, pump_en, lo_en, hi_en, ocp, hrdyo, hresp;
	pump_mode_type mode;
	logic [RAMP_W-1:0] str;
	pump_switch_type sw;
	sense_type sense_w;
	pump_mode_type nx [3] = '{PM_1P5X, PM_2X, PM_2X};
	int n_fail = 0, n_tests = 0, bad;
	assign sense_w = {pump_output, drop, sb, sa, hi, lo};
	always #50 CLK = ~CLK;
	enable_host host (.clk(CLK), .rstn(RSTN), .low_req(lo_req), .high_req(hi_req), .pwm_req(pwm_req),
		.low_sel(lo), .high_sel(hi));
	led_charge_pump_mode_control #(.HOLDOFF_CYCLES(HOLD), .DROPOUT_CYCLES(DROP)) dut (
		.CLK(CLK), .RSTN(RSTN), .SENSE(sense_w), .PUMP_ENABLE(pump_en), .LOW_CURRENT_EN(lo_en),
		.HIGH_CURRENT_EN(hi_en), .OVERCURRENT(ocp), .PUMP_MODE(mode), .PUMP_STRENGTH(str),
		.PUMP_SWITCHES(sw), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
		.HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdyo), .HREADYOUT(hrdyo), .HRDATA(hrdata), .HRESP(hresp));
	task cyc(input int n);
		repeat (n) @(posedge CLK);
	endtask : cyc
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task print_verdict;
		$display("comparisons=%0d mismatches=%0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : print_verdict
	task rdy;
		int i;
		i = 0;
		do begin
			@(posedge CLK);
			i++;
		end while (hrdyo !== 1'b1 && i < 16);
		if (hrdyo !== 1'b1) begin
			n_fail++;
			print_verdict;
		end
	endtask : rdy
	task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= wr;
		rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		rdy;
		rd = hrdata;
		chk(hresp, HRESP_OKAY);
	endtask : bus
	task en(input logic l, input logic h, input int n);
		lo_req <= l;
		hi_req <= h;
		cyc(n);
	endtask : en
	task sw_chk(input logic two);
		int ones;
		ones = 0;
		repeat (2 * PUMP_PERIOD_CYC) begin
			@(posedge CLK);
			ones += sw.phase_one;
			chk(sw.phase_one & sw.phase_two, 0);
			chk(two ? sw.cap_one_charge : sw.series_charge, sw.phase_one);
			chk(two ? sw.cap_two_charge : sw.parallel_stack, sw.phase_two);
		end
		chk(ones, 2 * (PUMP_HALF_CYC - 1));
	endtask : sw_chk
	initial begin
		cyc(4);
		RSTN <= 1'b1;
		cyc(1);
		chk(mode, PM_1X);
		chk(sw, 8'h01);
		bus(0, REG_CONFIG, 0);
		chk(rd, CFG_RESET);
		bus(0, 32'h0000_0010, 0);
		chk(rd, 0);
		$display("test reset done");
		for (int k = 1; k < 4; k++) begin
			en(k[0], k[1], 8);
			chk({pump_en, lo_en, hi_en}, {1'b1, k[0], k[1]});
		end
		en(0, 0, HOLD + 10);
		chk({pump_en, lo_en, hi_en, sw.weak_bypass}, 4'h1);
		$display("test decode done");
		en(0, 1, 8);
		en(0, 0, HOLD - 10);
		chk(pump_en, 1);
		en(0, 1, 8);
		en(0, 0, HOLD - 10);
		chk(pump_en, 1);
		cyc(20);
		chk(pump_en, 0);
		$display("test holdoff done");
		en(1, 0, 8);
		pwm_req <= 1'b1;
		bad = 0;
		repeat (1700) begin
			@(posedge CLK);
			if (pump_en !== 1'b1) bad++;
		end
		chk(bad, 0);
		drop <= 1'b1;
		cyc(900);
		chk(mode, PM_1X);
		cyc(200);
		chk(mode, PM_1P5X);
		drop <= 1'b0;
		bus(0, REG_STATUS, 0);
		chk(rd[ST_PWM_BIT], 1);
		pwm_req <= 1'b0;
		en(0, 0, HOLD + 10);
		chk(mode, PM_1X);
		$display("test pwm done");
		en(1, 0, 8);
		for (int i = 0; i < 3; i++) begin
			drop <= 1'b1;
			cyc(DROP - 10);
			chk(mode, i == 0 ? PM_1X : nx[i-1]);
			cyc(15);
			drop <= 1'b0;
			chk(mode, nx[i]);
			if (i < 2) chk(str < 11'h00A, 1);
			if (i == 0) sw_chk(0);
			cyc(1300);
			chk(str, SOFTSTART_CYC);
		end
		sw_chk(1);
		bus(0, REG_STATUS, 0);
		chk(rd[2:0], PM_2X);
		en(0, 0, HOLD + 10);
		chk(mode, PM_1X);
		en(1, 0, 8);
		chk({mode, sw.main_bypass}, {PM_1X, 1'b0});
		pump_output <= 1'b1;
		cyc(5);
		chk(sw.main_bypass, 1);
		$display("test stepping done");
		bus(1, REG_CONFIG, 0);
		bus(0, REG_CONFIG, 0);
		chk(rd, 0);
		drop <= 1'b1;
		cyc(DROP + 20);
		drop <= 1'b0;
		chk(mode, PM_1X);
		bus(1, REG_CONFIG, CFG_RESET);
		$display("test config done");
		for (int j = 0; j < 2; j++) begin
			en(1, 0, 8);
			{sb, sa} <= j ? 2'b10 : 2'b01;
			cyc(6);
			chk({ocp, pump_en, sw.weak_bypass}, 3'h5);
			{sb, sa} <= 2'b00;
			en(0, 0, HOLD + 10);
			chk(ocp, 0);
		end
		$display("test overcurrent done");
		print_verdict;
	end
endmodule : led_charge_pump_mode_control_tb_top
`default_nettype wire
